// ==== rtl/sadc_params.svh ====
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

`define SADC_RES_BITS 18
`define SADC_CNT_W 5
`define SADC_CLK_PERIOD_NS 5
`define SADC_CONV_TIME_NS 525
`define SADC_CONV_CYCLES (`SADC_CONV_TIME_NS / `SADC_CLK_PERIOD_NS)
`define SADC_RESULT_RESET 18'h00000

`endif

// ==== rtl/sadc_pkg.sv ====
package sadc_pkg;
    typedef enum logic [1:0]
    {
        SADC_IDLE = 2'b00,
        SADC_CONV = 2'b01,
        SADC_SLEEP = 2'b10
    } sadc_state_t;

    typedef struct packed
    {
        logic convert_start;
        logic serial_clk;
        logic read_select_or_chain_input;
        logic chain_select;
    } sadc_pins_t;
endpackage

// ==== rtl/sadc_readout.sv ====
// Contract
// RQ1 - Two convert starts with no serial clock rise between them request sleep.
// RQ2 - A pending sleep request takes effect when busy falls at conversion end.
// RQ3 - While asleep a serial clock rise wakes the device.
// RQ4 - The host waits the wake-up delay after waking before a new conversion.
// RQ5 - Result bits shift out only on serial clock edges with the output enabled.
// RQ6 - The output updates after each clock rise; host samples on next fall or rise.
// RQ7 - The result msb stays on the output until the first clock rise of readout.
// RQ8 - The host should read after conversion; a 40MHz shift clock keeps 1Msps.
// RQ9 - With chain select low, output is tri-stated while read select is high.
// RQ10 - In normal mode with read select low, the new msb shows at busy fall.
// RQ11 - Pulling read select low between conversions puts the msb on the output.
// RQ12 - With a shared output the host lowers only one read select at a time.
// RQ13 - With chain select high the output is always driven and the pin is data in.
// RQ14 - In chain mode the upstream msb appears after 18 serial clock cycles.
// RQ15 - In chain mode the upstream bit is captured on every serial clock rise; the code does not capture the rise that wakes it from sleep.
// RQ16 - Busy stays high for a whole conversion; further starts are ignored.
// RQ17 - The result shifts msb first from bit seventeen down to bit zero.
`timescale 1ns/10ps
`include "sadc_params.svh"
module sadc_readout
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic convert_start,
    input wire logic serial_clk,
    input wire logic read_select_or_chain_input,
    input wire logic chain_select,
    input wire logic [17:0] conv_result,
    output logic busy,
    output logic serial_out,
    output logic serial_out_oe_n,
    output logic asleep
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    sadc_pins_t pins_raw;
    sadc_pins_t pins_s;

    assign pins_raw = '{convert_start: convert_start,
                        serial_clk: serial_clk,
                        read_select_or_chain_input: read_select_or_chain_input,
                        chain_select: chain_select};

    sadc_sync u_sync_cnv
    (
        .clk(clk),
        .reset(reset),
        .din(pins_raw.convert_start),
        .dout(pins_s.convert_start)
    );
    sadc_sync u_sync_sck
    (
        .clk(clk),
        .reset(reset),
        .din(pins_raw.serial_clk),
        .dout(pins_s.serial_clk)
    );
    sadc_sync u_sync_rdl
    (
        .clk(clk),
        .reset(reset),
        .din(pins_raw.read_select_or_chain_input),
        .dout(pins_s.read_select_or_chain_input)
    );
    sadc_sync u_sync_chain
    (
        .clk(clk),
        .reset(reset),
        .din(pins_raw.chain_select),
        .dout(pins_s.chain_select)
    );

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    logic cnv_prev_q;
    logic sck_prev_q;
    logic cnv_rise;
    logic sck_rise;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnv_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            cnv_prev_q <= pins_s.convert_start;
            sck_prev_q <= pins_s.serial_clk;
        end
    end

    assign cnv_rise = pins_s.convert_start & ~cnv_prev_q;
    assign sck_rise = pins_s.serial_clk & ~sck_prev_q;

    // ****************************************************************
    // Conversion and sleep control
    // ****************************************************************
    sadc_state_t state_q;
    sadc_state_t state_d;
    logic [7:0] conv_cnt_q;
    logic [7:0] conv_cnt_d;
    logic cnv_seen_q;
    logic cnv_seen_d;
    logic sleep_req_q;
    logic sleep_req_d;
    logic busy_q;
    logic busy_d;
    logic conv_done;

    always_comb
    begin
        state_d = state_q;
        conv_cnt_d = conv_cnt_q;
        cnv_seen_d = cnv_seen_q;
        sleep_req_d = sleep_req_q;
        busy_d = busy_q;
        conv_done = 1'b0;
        if (sck_rise)
        begin
            cnv_seen_d = 1'b0;
        end
        case (state_q)
            SADC_IDLE:
            begin
                if (cnv_rise)
                begin
                    state_d = SADC_CONV;
                    busy_d = 1'b1;
                    conv_cnt_d = 8'h00;
                    if (cnv_seen_q && !sck_rise)
                    begin
                        sleep_req_d = 1'b1; // RQ1
                    end
                    cnv_seen_d = 1'b1;
                end
            end
            SADC_CONV:
            begin
                // Starts during conversion are ignored
                if (conv_cnt_q == 8'(`SADC_CONV_CYCLES - 1)) // RQ16
                begin
                    busy_d = 1'b0;
                    conv_done = 1'b1;
                    if (sleep_req_q)
                    begin
                        state_d = SADC_SLEEP; // RQ2
                        sleep_req_d = 1'b0;
                    end
                    else
                    begin
                        state_d = SADC_IDLE;
                    end
                end
                else
                begin
                    conv_cnt_d = conv_cnt_q + 8'h01;
                end
            end
            SADC_SLEEP:
            begin
                if (sck_rise)
                begin
                    state_d = SADC_IDLE; // RQ3
                end
            end
            default:
            begin
                state_d = SADC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= SADC_IDLE;
            conv_cnt_q <= 8'h00;
            cnv_seen_q <= 1'b0;
            sleep_req_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            conv_cnt_q <= conv_cnt_d;
            cnv_seen_q <= cnv_seen_d;
            sleep_req_q <= sleep_req_d;
            busy_q <= busy_d;
        end
    end

    // ****************************************************************
    // Serial shifter
    // ****************************************************************
    logic [17:0] shift_q;
    logic [17:0] shift_d;
    logic sdo_q;
    logic sdo_d;
    logic oe_n_q;
    logic oe_n_d;
    logic asleep_q;
    logic asleep_d;
    logic enabled;

    // Chain mode always drives; normal mode follows read select
    assign enabled = pins_s.chain_select |
                     ~pins_s.read_select_or_chain_input; // RQ9 RQ13

    always_comb
    begin
        shift_d = shift_q;
        if (conv_done)
        begin
            shift_d = conv_result; // RQ10
        end
        else if (sck_rise && enabled && state_q != SADC_SLEEP)
        begin
            // Upstream bit enters at lsb in chain mode
            shift_d = {shift_q[16:0],
                       pins_s.chain_select &
                       pins_s.read_select_or_chain_input}; // RQ5 RQ15 RQ17
        end
        sdo_d = shift_d[17]; // RQ6 RQ7 RQ11 RQ14
        oe_n_d = ~enabled;
        asleep_d = (state_d == SADC_SLEEP); // RQ2
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            shift_q <= `SADC_RESULT_RESET;
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
            asleep_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            sdo_q <= sdo_d;
            oe_n_q <= oe_n_d;
            asleep_q <= asleep_d;
        end
    end

    assign busy = busy_q;
    assign serial_out = sdo_q;
    assign serial_out_oe_n = oe_n_q;
    assign asleep = asleep_q;
endmodule

// ==== rtl/sadc_sync.sv ====
`timescale 1ns/10ps
module sadc_sync
(
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb
    begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule

// ==== tb/sadc_host.sv ====
`timescale 1ns/10ps
module sadc_host
(
    output logic serial_clk,
    output logic sdi
);
    // ******
    // Host shift clock and upstream data
    // ******
    initial
    begin
        serial_clk = 1'b0;
        sdi = 1'b0;
    end
    task automatic frame(input int n, input logic [17:0] up);
        for (int i = 0; i < n; i++)
        begin
            sdi = up[17];
            #32 serial_clk = 1'b1;
            #32 serial_clk = 1'b0;
            up = {up[16:0], ~up[17]};
        end
        sdi = ~sdi;
    endtask
endmodule

// ==== tb/sadc_readout_bench.sv ====
`timescale 1ns/10ps
`include "sadc_params.svh"
module sadc_readout_bench;
    // ******
    // Stimulus, monitor and verdict
    // ******
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic convert_start = 1'b0;
    logic rsel = 1'b0;
    logic chain_select = 1'b0;
    logic [17:0] conv_result = 18'h00000;
    logic serial_clk, sdi, busy, serial_out, serial_out_oe_n, asleep;
    logic [17:0] r, u;
    logic q[$];
    int mismatches = 0;
    int checks = 0;
    int seed = 26;
    // Host wait after wake, arbitrary model figure
    localparam int WAKE_CYCLES = 20;
    wire read_select_or_chain_input = chain_select ? sdi : rsel;
    wire sdo = serial_out_oe_n ? 1'bz : serial_out;
    always #2.5 clk = ~clk;
    sadc_readout sadc_readout_inst (.*);
    sadc_host sadc_host_inst (.*);
    task automatic chk(input logic [17:0] seen, exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, output int n);
        for (n = 0; n < 200 && busy !== lvl; n++)
            @(posedge clk);
        if (n == 200)
        begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic convert(input logic [17:0] v, input logic again);
        int n;
        int spent;
        spent = 0;
        @(posedge clk);
        conv_result <= v;
        convert_start <= 1'b1;
        wait_busy(1'b1, n);
        convert_start <= 1'b0;
        if (again)
        begin
            // Second start inside the conversion must be ignored
            repeat (8) @(posedge clk);
            convert_start <= 1'b1;
            repeat (8) @(posedge clk);
            convert_start <= 1'b0;
            spent = 16;
        end
        wait_busy(1'b0, n);
        chk(18'(n + spent), 18'(`SADC_CONV_CYCLES), "busy cycles");
    endtask
    task automatic expect_word(input logic [17:0] w);
        for (int i = 17; i >= 0; i--)
            q.push_back(w[i]);
    endtask
    always @(posedge serial_clk)
        chk(sdo, q.size() ? q.pop_front() : 1'bx, "bit");
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            r = $random(seed);
            rsel <= k[0];
            convert(r, k == 2);
            repeat (6) @(posedge clk);
            chk(serial_out_oe_n, k[0], "oe_n");
            chk(asleep, 1'b0, "asleep");
            rsel <= 1'b0;
            repeat (6) @(posedge clk);
            chk(sdo, r[17], "msb");
            expect_word(r);
            sadc_host_inst.frame(18, r);
        end
        @(posedge clk);
        chain_select <= 1'b1;
        r = $random(seed);
        u = $random(seed);
        convert(r, 1'b0);
        chk(serial_out_oe_n, 1'b0, "oe_n");
        expect_word(r);
        expect_word(u);
        sadc_host_inst.frame(36, u);
        @(posedge clk);
        chain_select <= 1'b0;
        convert(r, 1'b0);
        convert(u, 1'b0);
        repeat (2) @(posedge clk);
        chk(asleep, 1'b1, "asleep");
        q.push_back(u[17]);
        sadc_host_inst.frame(1, u);
        repeat (8) @(posedge clk);
        chk(asleep, 1'b0, "asleep");
        repeat (WAKE_CYCLES) @(posedge clk);
        r = $random(seed);
        convert(r, 1'b0);
        chk(asleep, 1'b0, "asleep");
        expect_word(r);
        sadc_host_inst.frame(18, r);
        @(posedge clk);
        chk(18'(q.size()), 18'h00000, "bits left");
        end_sim();
    end
endmodule

// ==== tb/sadc_readout_checker.sv ====
`timescale 1ns/10ps
module sadc_readout_checker
(
    input wire logic clk,
    input wire logic reset,
    input wire logic convert_start,
    input wire logic serial_clk,
    input wire logic read_select_or_chain_input,
    input wire logic chain_select,
    input wire logic [17:0] conv_result,
    input wire logic busy,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic asleep
);
    // ******
    // Port timing checks
    // ******
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    wire off_req = !chain_select && read_select_or_chain_input;
    a_oe_off: assert property (off_req [*6] |-> serial_out_oe_n)
        else $error("output not released");
    a_oe_on: assert property ((!off_req) [*6] |-> !serial_out_oe_n)
        else $error("output not driven");
    a_start_busy: assert property ($rose(convert_start) && !busy
        && !asleep |-> ##[2:5] busy) else $error("start not taken");
    a_busy_len: assert property ($rose(busy)
        |-> ##104 busy ##1 !busy) else $error("busy length wrong");
    a_msb_load: assert property ($fell(busy)
        |-> serial_out == conv_result[17]) else $error("msb not loaded");
    a_sleep_entry: assert property ($rose(asleep)
        |-> $past(busy) || $past(busy, 2)) else $error("sleep off busy");
    a_wake_up: assert property (asleep && $rose(serial_clk)
        |-> ##[1:6] !asleep) else $error("no wake on clock");
    a_out_hold: assert property ((!serial_clk && !busy) [*6]
        |-> $stable(serial_out)) else $error("output moved idle");
endmodule
bind sadc_readout sadc_readout_checker sadc_readout_checker_inst (.*);
